// ---- src/two_wire_master.sv ----
// Contract
// RL1: Commands: none, ack then restart, ack then stop
// RL2: Command two: receive acks and reads, send waits
// RL3: Ack choice and command in one write
// RL4: Flags clear on address, data or command access
// RL5: Read done only after clean read, acked address
// RL6: Read starts on data read or address bit0
// RL7: Writing one clears a status flag
// RL8: Write done set after every write and every address except an acked read address
// RL9: Stretch flag set while SCL held, clears on access
// RL10: Status bit four shows last received ack
// RL11: Arbitration lost on high bit, nack, start
// RL12: Misplaced start or stop sets illegal condition flag
// RL13: Error detection only while enabled, fast clock
// RL14: Line state codes, unknown when off, force idle
// RL15: Baud sets SCL times, change while disabled
// RL16: Address write when unknown flags error, no drive
// RL17: Busy waits idle, start, send, hold, flag
// RL18: Owner restarts at once, ack first after read
// RL19: Read address receives one byte before flag
// RL20: Address write clears all master flags
// RL21: Address register read has no side effect
// RL22: Address bit zero is the direction bit
// RL23: Data write sends byte, ack, write flag
// RL24: Data read sends ack then one byte in
// RL25: Ack choice zero sends ack, resets to ack
// RL26: Open drain lines, sampled on system clock
// RL27: Software aborts or rewrites address after loss
`timescale 1ns/1ps
`include "twm_defines.svh"
module two_wire_master
	import twm_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Register port
	input wire regbus_s BUS,
	output logic [7:0] RDATA,
	// Clock line
	input wire logic SCL_I,
	output logic SCL_O,
	output logic SCL_OE,
	// Data line
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE
);

	mst_s s_q, s_d;
	logic [1:0] lines_s;
	logic scl_s, sda_s, tick, tick_clr;
	logic start_cond, stop_cond, foreign, abort;
	logic wr_ctl1, wr_ctl2, wr_stat, wr_baud, wr_addr, wr_data, rd_data;
	logic ack_now;
	logic [1:0] cmd;

	// Line sampling
	line_sync u_sync (
		.clk(CLK),
		.rst(RST),
		.din({SCL_I, SDA_I}),
		.dout(lines_s)
	);
	assign scl_s = lines_s[1];
	assign sda_s = lines_s[0];

	// Quarter bit timing
	baud_tick u_tick (
		.clk(CLK),
		.rst(RST),
		.clr(tick_clr),
		.baud(s_q.baud),
		.tick(tick)
	);
	assign tick_clr = (s_q.st == S_OFF) || (s_q.st == S_IDLE) || (s_q.st == S_WAIT_BUS) || (s_q.st == S_HOLD);

	// Register decode
	assign wr_ctl1 = BUS.wr && (BUS.addr == `TWM_OFS_CTRL1);
	assign wr_ctl2 = BUS.wr && (BUS.addr == `TWM_OFS_CTRL2);
	assign wr_stat = BUS.wr && (BUS.addr == `TWM_OFS_STATUS);
	assign wr_baud = BUS.wr && (BUS.addr == `TWM_OFS_BAUD);
	assign wr_addr = BUS.wr && (BUS.addr == `TWM_OFS_ADDR);
	assign wr_data = BUS.wr && (BUS.addr == `TWM_OFS_DATA);
	assign rd_data = BUS.rd && (BUS.addr == `TWM_OFS_DATA);
	assign cmd = BUS.wdata[1:0];
	assign ack_now = wr_ctl2 ? BUS.wdata[`TWM_CTRL2_ACK] : s_q.ack_choice; // RL3

	// Conditions seen on the lines
	assign start_cond = s_q.scl_d && scl_s && s_q.sda_d && !sda_s; // RL26
	assign stop_cond = s_q.scl_d && scl_s && !s_q.sda_d && sda_s;
	assign foreign = (s_q.st == S_BIT) || (s_q.st == S_ACKOUT);
	assign abort = s_q.enable && foreign && (start_cond || stop_cond); // RL12

	always_comb begin
		s_d = s_q;
		s_d.scl_d = scl_s;
		s_d.sda_d = sda_s;
		s_d.rdata = `TWM_RST_BYTE;
		s_d.drive_lvl = 1'b0;

		// Register reads
		if (BUS.rd) begin
			unique case (BUS.addr)
				`TWM_OFS_CTRL1: s_d.rdata = {7'h00, s_q.enable};
				`TWM_OFS_CTRL2: s_d.rdata = {5'h00, s_q.ack_choice, 2'h0};
				`TWM_OFS_STATUS: s_d.rdata = {s_q.read_done_flag, s_q.write_done_flag, s_q.hold, s_q.last_ack, s_q.arb, s_q.berr,
						s_q.lstate};
				`TWM_OFS_BAUD: s_d.rdata = s_q.baud;
				`TWM_OFS_ADDR: s_d.rdata = s_q.addr; // RL21
				`TWM_OFS_DATA: s_d.rdata = s_q.shift;
				default: s_d.rdata = `TWM_RST_BYTE;
			endcase
		end

		// Register writes and flag clears
		if (wr_ctl1) begin
			s_d.enable = BUS.wdata[`TWM_CTRL1_ENABLE];
		end
		if (wr_ctl2) begin
			s_d.ack_choice = BUS.wdata[`TWM_CTRL2_ACK]; // RL25
		end
		if (wr_baud) begin
			s_d.baud = BUS.wdata; // RL15
		end
		if (wr_stat) begin
			if (BUS.wdata[`TWM_ST_RIF]) s_d.read_done_flag = 1'b0; // RL7
			if (BUS.wdata[`TWM_ST_WIF]) s_d.write_done_flag = 1'b0; // RL7
			if (BUS.wdata[`TWM_ST_HOLD]) s_d.hold = 1'b0; // RL9
			if (BUS.wdata[`TWM_ST_ARB]) s_d.arb = 1'b0; // RL7
			if (BUS.wdata[`TWM_ST_BERR]) s_d.berr = 1'b0; // RL7
			if (BUS.wdata[1:0] == `TWM_LS_IDLE && s_q.enable) s_d.lstate = `TWM_LS_IDLE; // RL14
		end
		if (wr_addr) begin
			s_d.addr = BUS.wdata;
			s_d.read_done_flag = 1'b0; // RL20
			s_d.write_done_flag = 1'b0; // RL20
			s_d.hold = 1'b0; // RL9
			s_d.arb = 1'b0; // RL20
			s_d.berr = 1'b0; // RL20
		end
		if (wr_data || rd_data || (wr_ctl2 && cmd != `TWM_CMD_NONE)) begin
			s_d.read_done_flag = 1'b0; // RL4
			s_d.write_done_flag = 1'b0; // RL4
			s_d.hold = 1'b0; // RL9
		end

		// Line state tracker
		if (s_q.enable) begin
			if (start_cond) s_d.after_start = 1'b1;
			else if (s_q.scl_d && !scl_s) s_d.after_start = 1'b0;
			if (stop_cond) begin
				s_d.lstate = `TWM_LS_IDLE;
				if (s_q.after_start) s_d.berr = 1'b1; // RL12 RL13
			end else if (start_cond && s_q.lstate != `TWM_LS_OWNER && s_q.st != S_START
					&& s_q.st != S_RSTART) begin
				s_d.lstate = `TWM_LS_BUSY;
			end
		end

		if (abort) begin
			s_d.berr = 1'b1; // RL12
			s_d.write_done_flag = 1'b1; // RL8
			s_d.st = S_IDLE;
			s_d.scl_oe = 1'b0;
			s_d.sda_oe = 1'b0;
		end else begin
			// Address write starts or restarts a transfer
			if (wr_addr && s_q.enable && (s_q.st == S_IDLE || s_q.st == S_HOLD || s_q.st == S_WAIT_BUS)) begin
				s_d.shift = BUS.wdata;
				s_d.rx = 1'b0;
				s_d.addr_phase = 1'b1;
				s_d.addr_acked = 1'b0;
				s_d.lost = 1'b0;
				s_d.q = `TWM_Q_LOW;
				unique case (s_q.lstate)
					`TWM_LS_UNKNOWN: begin
						s_d.write_done_flag = 1'b1; // RL16
						s_d.berr = 1'b1; // RL16
						s_d.st = S_IDLE;
					end
					`TWM_LS_OWNER: begin
						if (s_q.st == S_HOLD && s_q.rx) begin
							s_d.ackbit = s_q.ack_choice; // RL18
							s_d.nxt = N_RESTART;
							s_d.st = S_ACKOUT;
						end else begin
							s_d.st = S_RSTART; // RL18
						end
					end
					`TWM_LS_IDLE: s_d.st = S_START;
					`TWM_LS_BUSY: s_d.st = S_WAIT_BUS; // RL17
				endcase
			end else begin
				unique case (s_q.st)
					S_OFF: begin
						if (s_q.enable) s_d.st = S_IDLE;
					end
					S_IDLE: begin
						s_d.scl_oe = 1'b0;
						s_d.sda_oe = 1'b0;
					end
					S_WAIT_BUS: begin
						if (s_q.lstate == `TWM_LS_IDLE) s_d.st = S_START; // RL17
					end
					S_RSTART: begin
						if (tick && s_q.q == `TWM_Q_LOW) begin
							s_d.sda_oe = 1'b0;
							s_d.q = `TWM_Q_SETTLE;
						end else if (tick && s_q.q == `TWM_Q_SETTLE) begin
							s_d.scl_oe = 1'b0;
							s_d.q = `TWM_Q_RISE;
						end else if (tick && s_q.q == `TWM_Q_RISE && scl_s) begin
							s_d.st = S_START;
							s_d.q = `TWM_Q_LOW;
						end
					end
					S_START: begin
						if (tick && s_q.q == `TWM_Q_LOW) begin
							if (!sda_s || !scl_s) begin
								s_d.arb = 1'b1; // RL11
								s_d.write_done_flag = 1'b1;
								s_d.lstate = `TWM_LS_BUSY;
								s_d.st = S_IDLE;
							end else begin
								s_d.sda_oe = 1'b1;
								s_d.q = `TWM_Q_SETTLE;
							end
						end else if (tick && s_q.q == `TWM_Q_SETTLE) begin
							s_d.scl_oe = 1'b1;
							s_d.lstate = `TWM_LS_OWNER; // RL14
							s_d.st = S_BIT;
							s_d.bitn = 4'h0;
							s_d.q = `TWM_Q_LOW;
						end
					end
					S_BIT, S_ACKOUT: begin
						if (tick && s_q.q == `TWM_Q_LOW) begin
							if (s_q.st == S_ACKOUT) s_d.sda_oe = !s_q.ackbit; // RL25
							else s_d.sda_oe = !s_q.rx && s_q.bitn <= `TWM_LAST_DATA_BIT && !s_q.shift[7]
									&& !s_q.lost;
							s_d.q = `TWM_Q_SETTLE;
						end else if (tick && s_q.q == `TWM_Q_SETTLE) begin
							s_d.scl_oe = 1'b0;
							s_d.q = `TWM_Q_RISE;
						end else if (tick && s_q.q == `TWM_Q_RISE && scl_s) begin
							s_d.q = `TWM_Q_HIGH;
						end else if (tick && s_q.q == `TWM_Q_HIGH) begin
							s_d.scl_oe = 1'b1;
							s_d.q = `TWM_Q_LOW;
							s_d.bitn = s_q.bitn + 4'h1;
							if (s_q.st == S_ACKOUT) begin
								// SDA kept past the SCL fall, released in the next low quarter except before a stop
								if (s_q.ackbit && !sda_s) begin
									s_d.arb = 1'b1; // RL11
									s_d.write_done_flag = 1'b1; // RL24
									s_d.lstate = `TWM_LS_BUSY;
									s_d.scl_oe = 1'b0;
									s_d.st = S_IDLE;
								end else begin
									unique case (s_q.nxt)
										N_READ: begin
											s_d.st = S_BIT; // RL24
											s_d.rx = 1'b1;
											s_d.bitn = 4'h0;
										end
										N_RESTART: begin
											s_d.st = S_RSTART;
											s_d.shift = s_q.addr;
											s_d.rx = 1'b0;
											s_d.addr_phase = 1'b1;
											s_d.addr_acked = 1'b0;
										end
										N_STOP: s_d.st = S_STOP;
										default: s_d.st = S_IDLE;
									endcase
								end
							end else if (s_q.rx) begin
								s_d.shift = {s_q.shift[6:0], sda_s};
								if (s_q.bitn == `TWM_LAST_DATA_BIT) begin
									if (s_q.lost || !s_q.addr_acked) s_d.write_done_flag = 1'b1;
									else s_d.read_done_flag = 1'b1; // RL5
									s_d.hold = 1'b1; // RL9
									s_d.st = S_HOLD;
								end
							end else if (s_q.bitn <= `TWM_LAST_DATA_BIT) begin
								s_d.shift = {s_q.shift[6:0], sda_s};
								if ((s_q.shift[7] || s_q.lost) && !sda_s) begin
									s_d.lost = 1'b1;
									s_d.arb = 1'b1; // RL11
								end
							end else begin
								s_d.sda_oe = 1'b0;
								s_d.last_ack = sda_s; // RL10
								s_d.addr_phase = 1'b0;
								if (s_q.addr_phase && s_q.addr[0] && !sda_s && !s_q.lost) begin
									s_d.addr_acked = 1'b1; // RL22
									s_d.rx = 1'b1; // RL19
									s_d.bitn = 4'h0;
								end else begin
									s_d.write_done_flag = 1'b1; // RL8 RL23
									if (s_q.lost) begin
										s_d.scl_oe = 1'b0;
										s_d.lstate = `TWM_LS_BUSY;
										s_d.st = S_IDLE;
									end else begin
										s_d.hold = 1'b1; // RL17
										s_d.st = S_HOLD;
									end
								end
							end
						end
					end
					S_HOLD: begin
						s_d.scl_oe = 1'b1;
						if (rd_data && s_q.rx) begin
							s_d.ackbit = s_q.ack_choice; // RL6 RL24
							s_d.nxt = N_READ;
							s_d.st = S_ACKOUT;
						end else if (wr_data) begin
							s_d.shift = BUS.wdata; // RL23
							s_d.rx = 1'b0;
							s_d.lost = 1'b0;
							s_d.bitn = 4'h0;
							s_d.st = S_BIT;
						end else if (wr_ctl2 && cmd != `TWM_CMD_NONE) begin
							s_d.ackbit = ack_now; // RL3
							unique case (cmd)
								`TWM_CMD_RESTART: s_d.nxt = N_RESTART; // RL1
								`TWM_CMD_NEXT: s_d.nxt = N_READ; // RL2
								`TWM_CMD_STOP: s_d.nxt = N_STOP; // RL1
								default: s_d.nxt = s_q.nxt;
							endcase
							if (s_q.rx) begin
								s_d.st = S_ACKOUT;
							end else if (cmd == `TWM_CMD_RESTART) begin
								s_d.shift = s_q.addr;
								s_d.addr_phase = 1'b1;
								s_d.addr_acked = 1'b0;
								s_d.st = S_RSTART;
							end else if (cmd == `TWM_CMD_STOP) begin
								s_d.st = S_STOP;
							end
						end
					end
					S_STOP: begin
						if (tick && s_q.q == `TWM_Q_LOW) begin
							s_d.sda_oe = 1'b1;
							s_d.q = `TWM_Q_SETTLE;
						end else if (tick && s_q.q == `TWM_Q_SETTLE) begin
							s_d.scl_oe = 1'b0;
							s_d.q = `TWM_Q_RISE;
						end else if (tick && s_q.q == `TWM_Q_RISE && scl_s) begin
							s_d.sda_oe = 1'b0;
							s_d.q = `TWM_Q_HIGH;
						end else if (tick && s_q.q == `TWM_Q_HIGH) begin
							s_d.lstate = `TWM_LS_IDLE;
							s_d.st = S_IDLE;
						end
					end
					default: s_d.st = S_OFF;
				endcase
			end
		end

		// Disabled master releases the lines
		if (!s_d.enable) begin
			s_d.st = S_OFF;
			s_d.lstate = `TWM_LS_UNKNOWN; // RL14
			s_d.scl_oe = 1'b0;
			s_d.sda_oe = 1'b0;
			s_d.after_start = 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			s_q <= '0;
			s_q.ack_choice <= `TWM_RST_ACK; // RL25
			s_q.scl_d <= 1'b1;
			s_q.sda_d <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign RDATA = s_q.rdata;
	assign SCL_O = s_q.drive_lvl; // RL26
	assign SCL_OE = s_q.scl_oe;
	assign SDA_O = s_q.drive_lvl;
	assign SDA_OE = s_q.sda_oe;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	sequence hold_tx;
		s_q.st == S_HOLD && !s_q.rx && s_q.enable;
	endsequence
	sequence hold_rx;
		s_q.st == S_HOLD && s_q.rx && s_q.enable;
	endsequence

	chk_cmd_stop_go: assert property (hold_tx ##0 (wr_ctl2 && cmd == `TWM_CMD_STOP) |=> s_q.st == S_STOP) // RL1
		else $error("stop command did not start stop");
	chk_cmd_next_rx: assert property (hold_rx ##0 (wr_ctl2 && cmd == `TWM_CMD_NEXT)
			|=> s_q.st == S_ACKOUT && s_q.nxt == N_READ) // RL2
		else $error("next byte command did not ack then read");
	chk_ack_same_write: assert property (hold_rx ##0 (wr_ctl2 && cmd != `TWM_CMD_NONE)
			|=> s_q.ackbit == $past(BUS.wdata[2])) // RL3
		else $error("ack choice of same write not used");
	chk_addr_clears_all: assert property (wr_addr && s_q.lstate != `TWM_LS_UNKNOWN && !abort && s_q.st == S_HOLD
			|=> !s_q.read_done_flag && !s_q.write_done_flag && !s_q.arb && !s_q.berr && !s_q.hold) // RL20
		else $error("address write left a flag set");
	chk_unknown_addr: assert property (s_q.enable && wr_addr && s_q.lstate == `TWM_LS_UNKNOWN && s_q.st == S_IDLE
			|=> s_q.write_done_flag && s_q.berr && !s_q.scl_oe && !s_q.sda_oe && s_q.st == S_IDLE) // RL16
		else $error("unknown state address write mishandled");
	chk_ack_latch: assert property (s_q.st == S_BIT && !s_q.rx && s_q.bitn == 4'h8 && s_q.q == 2'h3 && tick && !abort
			|=> s_q.last_ack == $past(sda_s) && s_q.write_done_flag != s_q.rx) // RL10
		else $error("received ack not latched");
	chk_off_unknown: assert property (!s_q.enable |-> s_q.lstate == `TWM_LS_UNKNOWN && !s_q.scl_oe && !s_q.sda_oe) // RL14
		else $error("disabled master not unknown and released");
	chk_force_idle: assert property (s_q.enable && wr_stat && BUS.wdata[1:0] == 2'h1 && !start_cond && !stop_cond
			&& !foreign && !wr_ctl1 |=> s_q.lstate == `TWM_LS_IDLE) // RL14
		else $error("force idle ignored");
	chk_hold_stretch: assert property (s_q.st != S_HOLD ##1 s_q.st == S_HOLD |-> s_q.hold && s_q.scl_oe) // RL9
		else $error("hold entered without stretch flag");
	chk_read_trigger: assert property (hold_rx ##0 (rd_data && !wr_addr)
			|=> s_q.st == S_ACKOUT ##1 s_q.st == S_ACKOUT) // RL24
		else $error("data read did not send ack");
	chk_rif_clean: assert property ($rose(s_q.read_done_flag) |-> s_q.addr_acked && !s_q.write_done_flag) // RL5
		else $error("read flag set without acked address");

endmodule : two_wire_master

// ---- src/twm_defines.svh ----
`ifndef TWM_DEFINES_SVH
`define TWM_DEFINES_SVH

// Register offsets
`define TWM_OFS_CTRL1 4'h3
`define TWM_OFS_CTRL2 4'h4
`define TWM_OFS_STATUS 4'h5
`define TWM_OFS_BAUD 4'h6
`define TWM_OFS_ADDR 4'h7
`define TWM_OFS_DATA 4'h8

// Field positions
`define TWM_CTRL1_ENABLE 0
`define TWM_CTRL2_ACK 2
`define TWM_ST_RIF 7
`define TWM_ST_WIF 6
`define TWM_ST_HOLD 5
`define TWM_ST_LAST_ACK_RECEIVED 4
`define TWM_ST_ARB 3
`define TWM_ST_BERR 2

// Command codes
`define TWM_CMD_NONE 2'h0
`define TWM_CMD_RESTART 2'h1
`define TWM_CMD_NEXT 2'h2
`define TWM_CMD_STOP 2'h3

// Line state codes
`define TWM_LS_UNKNOWN 2'h0
`define TWM_LS_IDLE 2'h1
`define TWM_LS_OWNER 2'h2
`define TWM_LS_BUSY 2'h3

// Reset values
`define TWM_RST_BYTE 8'h00
`define TWM_RST_ACK 1'h0
`define TWM_RST_LINES 2'h3

// Timing counts
`define TWM_LAST_DATA_BIT 4'h7
`define TWM_ACK_SLOT 4'h8
`define TWM_Q_LOW 2'h0
`define TWM_Q_SETTLE 2'h1
`define TWM_Q_RISE 2'h2
`define TWM_Q_HIGH 2'h3

`endif

// ---- src/twm_pkg.sv ----
package twm_pkg;

	typedef enum logic [3:0] {
		S_OFF,
		S_IDLE,
		S_WAIT_BUS,
		S_START,
		S_RSTART,
		S_BIT,
		S_ACKOUT,
		S_HOLD,
		S_STOP
	} mst_e;

	typedef enum logic [1:0] {
		N_READ,
		N_RESTART,
		N_STOP
	} nxt_e;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} regbus_s;

	typedef struct packed {
		logic [1:0] meta;
		logic [1:0] stable;
	} sync_s;

	typedef struct packed {
		logic [7:0] cnt;
		logic tick;
	} tick_s;

	typedef struct packed {
		mst_e st;
		nxt_e nxt;
		logic [1:0] q;
		logic [3:0] bitn;
		logic [7:0] shift;
		logic [7:0] addr;
		logic [7:0] baud;
		logic [7:0] rdata;
		logic enable;
		logic ack_choice;
		logic ackbit;
		logic rx;
		logic addr_phase;
		logic addr_acked;
		logic lost;
		logic read_done_flag;
		logic write_done_flag;
		logic hold;
		logic last_ack;
		logic arb;
		logic berr;
		logic [1:0] lstate;
		logic scl_oe;
		logic sda_oe;
		logic drive_lvl;
		logic scl_d;
		logic sda_d;
		logic after_start;
	} mst_s;

endpackage : twm_pkg

// ---- src/line_sync.sv ----
`timescale 1ns/1ps
`include "twm_defines.svh"
module line_sync
	import twm_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Lines
	input wire logic [1:0] din,
	output logic [1:0] dout
);

	sync_s y_q, y_d;

	always_comb begin
		y_d.meta = din;
		y_d.stable = y_q.meta;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			y_q <= {`TWM_RST_LINES, `TWM_RST_LINES};
		end else begin
			y_q <= y_d;
		end
	end

	assign dout = y_q.stable;

endmodule : line_sync

// ---- src/baud_tick.sv ----
`timescale 1ns/1ps
`include "twm_defines.svh"
module baud_tick
	import twm_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic clr,
	input wire logic [7:0] baud,
	// Quarter bit pulse
	output logic tick
);

	tick_s t_q, t_d;

	always_comb begin
		t_d = t_q;
		t_d.tick = 1'b0;
		if (clr) begin
			t_d.cnt = `TWM_RST_BYTE;
		end else if (t_q.cnt == baud) begin
			t_d.cnt = `TWM_RST_BYTE;
			t_d.tick = 1'b1;
		end else begin
			t_d.cnt = t_q.cnt + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			t_q <= '0;
		end else begin
			t_q <= t_d;
		end
	end

	assign tick = t_q.tick;

endmodule : baud_tick

// ---- tb/twm_slave_model.sv ----
`timescale 1ns/1ps
module twm_slave_model #(
	parameter logic [7:0] READ_BYTE = 8'hC3
) (
	// Bus wires
	input wire logic scl,
	input wire logic sda,
	// Data pull-down
	output logic sda_oe,
	// Observed traffic
	output logic [7:0] got_addr,
	output logic [7:0] got_data,
	output logic mack
);
	int bitc;
	logic [7:0] sh;
	logic rd_mode;
	logic in_addr;

	initial begin
		bitc = -1;
		sh = 8'h00;
		rd_mode = 1'b0;
		in_addr = 1'b0;
		sda_oe = 1'b0;
		got_addr = 8'h00;
		got_data = 8'h00;
		mack = 1'b0;
	end

	// Start or repeated start
	always @(negedge sda) if (scl === 1'b1) begin
		bitc = -1;
		in_addr = 1'b1;
		rd_mode = 1'b0;
	end

	// Stop
	always @(posedge sda) if (scl === 1'b1) begin
		bitc = -1;
		rd_mode = 1'b0;
	end

	// Sample bits and the master's ack
	always @(posedge scl) begin
		if (!rd_mode && bitc >= 0 && bitc < 8) sh = {sh[6:0], sda};
		if (rd_mode && bitc == 8) mack = sda;
	end

	// Drive ack or read bits while SCL low, release afterwards
	always @(negedge scl) begin
		bitc = bitc + 1;
		if (bitc == 9) begin
			rd_mode = in_addr ? sh[0] : (rd_mode & ~mack);
			in_addr = 1'b0;
			bitc = 0;
			sda_oe <= rd_mode ? ~READ_BYTE[7] : 1'b0;
		end else if (rd_mode) begin
			sda_oe <= (bitc < 8) ? ~READ_BYTE[7 - bitc] : 1'b0;
		end else if (bitc == 8) begin
			sda_oe <= 1'b1;
			if (in_addr) got_addr = sh;
			else got_data = sh;
		end
	end
endmodule : twm_slave_model

// ---- tb/two_wire_master_tb.sv ----
`timescale 1ns/1ps
`include "twm_defines.svh"
module two_wire_master_tb;
	import twm_pkg::*;

	logic clk;
	logic rst;
	regbus_s bus;
	logic [7:0] rdata;
	logic scl_o, scl_oe, sda_o, sda_oe, sl_oe, mack, ext_oe;
	logic [7:0] got_addr, got_data;
	wire logic scl_w = ~scl_oe;
	wire logic sda_w = ~(sda_oe | sl_oe | ext_oe);
	int failures = 0;
	int n_checks = 0;

	two_wire_master i_two_wire_master (.CLK(clk), .RST(rst), .BUS(bus), .RDATA(rdata),
		.SCL_I(scl_w), .SCL_O(scl_o), .SCL_OE(scl_oe), .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE(sda_oe));
	twm_slave_model i_twm_slave_model (.scl(scl_w), .sda(sda_w), .sda_oe(sl_oe),
		.got_addr(got_addr), .got_data(got_data), .mack(mack));

	initial clk = 1'b0;
	always #4 clk = ~clk;

	task automatic give_verdict();
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus <= '0;
		#1;
		d = rdata;
	endtask : rd

	task automatic chk_rd(input logic [3:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		chk(d, exp);
	endtask : chk_rd

	// Poll status until masked bits match
	task automatic wait_st(input logic [7:0] mask, input logic [7:0] exp);
		logic [7:0] s;
		for (int n = 0; n < 4000; n++) begin
			rd(`TWM_OFS_STATUS, s);
			if ((s & mask) === exp) return;
		end
		failures++;
		$display("[FAIL] t=%0t status=%h exp=%h", $time, s, exp);
	endtask : wait_st

	task automatic t_reset();
		chk_rd(`TWM_OFS_STATUS, 8'h00);
		chk_rd(`TWM_OFS_BAUD, 8'h00);
		chk_rd(`TWM_OFS_ADDR, 8'h00);
		chk_rd(`TWM_OFS_DATA, 8'h00);
		chk_rd(4'hF, 8'h00);
		chk({4'h0, scl_o, sda_o, scl_oe, sda_oe}, 8'h00);
		wr(`TWM_OFS_BAUD, 8'h03);
		chk_rd(`TWM_OFS_BAUD, 8'h03);
		wr(`TWM_OFS_CTRL1, 8'h01);
	endtask : t_reset

	task automatic t_unknown();
		wr(`TWM_OFS_ADDR, 8'hA0);
		wait_st(8'h40, 8'h40);
		chk_rd(`TWM_OFS_STATUS, 8'h44);
		chk({6'h00, scl_oe, sda_oe}, 8'h00);
	endtask : t_unknown

	task automatic t_force_idle();
		wr(`TWM_OFS_STATUS, 8'h01);
		chk_rd(`TWM_OFS_STATUS, 8'h45);
		wr(`TWM_OFS_STATUS, 8'h44);
		chk_rd(`TWM_OFS_STATUS, 8'h01);
	endtask : t_force_idle

	// Another party's start then stop on an idle bus
	task automatic t_foreign();
		@(posedge clk);
		ext_oe <= 1'b1;
		repeat (4) @(posedge clk);
		chk_rd(`TWM_OFS_STATUS, 8'h03);
		@(posedge clk);
		ext_oe <= 1'b0;
		repeat (4) @(posedge clk);
		chk_rd(`TWM_OFS_STATUS, 8'h05);
		wr(`TWM_OFS_STATUS, 8'h04);
		chk_rd(`TWM_OFS_STATUS, 8'h01);
	endtask : t_foreign

	task automatic t_write();
		wr(`TWM_OFS_ADDR, 8'hA0);
		wait_st(8'h40, 8'h40);
		chk_rd(`TWM_OFS_STATUS, 8'h62);
		chk(got_addr, 8'hA0);
		chk_rd(`TWM_OFS_ADDR, 8'hA0);
		chk_rd(`TWM_OFS_STATUS, 8'h62);
		wr(`TWM_OFS_DATA, 8'h5A);
		chk_rd(`TWM_OFS_STATUS, 8'h02);
		wait_st(8'h40, 8'h40);
		chk_rd(`TWM_OFS_STATUS, 8'h62);
		chk(got_data, 8'h5A);
		wr(`TWM_OFS_STATUS, 8'h40);
		chk_rd(`TWM_OFS_STATUS, 8'h22);
	endtask : t_write

	task automatic t_read();
		wr(`TWM_OFS_ADDR, 8'hA1);
		chk_rd(`TWM_OFS_STATUS, 8'h02);
		wait_st(8'h80, 8'h80);
		chk_rd(`TWM_OFS_STATUS, 8'hA2);
		chk(got_addr, 8'hA1);
		chk_rd(`TWM_OFS_DATA, 8'hC3);
		wait_st(8'h80, 8'h80);
		chk({7'h00, mack}, 8'h00);
		wr(`TWM_OFS_CTRL2, 8'h02);
		wait_st(8'h80, 8'h80);
		chk_rd(`TWM_OFS_STATUS, 8'hA2);
		wr(`TWM_OFS_CTRL2, 8'h07);
		wait_st(8'hFF, 8'h01);
		chk({7'h00, mack}, 8'h01);
		chk({6'h00, scl_w, sda_w}, 8'h03);
		chk_rd(`TWM_OFS_CTRL2, 8'h04);
		chk_rd(`TWM_OFS_DATA, 8'hC3);
		chk_rd(`TWM_OFS_STATUS, 8'h01);
	endtask : t_read

	task automatic t_disable();
		wr(`TWM_OFS_CTRL1, 8'h00);
		chk_rd(`TWM_OFS_STATUS, 8'h00);
	endtask : t_disable

	initial begin
		bus = '0;
		ext_oe = 1'b0;
		rst = 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_unknown();
		// Software forces the line state idle after an error
		t_force_idle();
		t_foreign();
		t_write();
		t_read();
		t_disable();
		give_verdict();
	end

	initial begin
		#400000;
		failures++;
		$display("[FAIL] t=%0t watchdog=%h exp=%h", $time, 8'h01, 8'h00);
		give_verdict();
	end
endmodule : two_wire_master_tb
